// file: qd_decoder.v
`include "qd_decoder_regs.vh"

// Behaviour
// - led strobe turns on lead time before each sample, off right after.
// - led pin active level follows the led polarity setting.
// - disconnected led selection claims no pin, leaving it to the processor.
// - debounce samples each phase at 1 MHz; pass level only if all agree.
// - debounce kills levels shorter than one period, passes over two periods.
// - led stays on continuously while debounce is enabled.
// - debounced displacement lags raw input by at most one extra period.
// - motion accumulator adds +1/-1 steps, never double transitions.
// - overflowing step raises overflow event and is dropped; later steps count.
// - double accumulator counts double transitions since last clear, holding at 15.
// - combined task snapshots and clears both accumulators in one step.
// - motion task snapshots and clears motion accumulator only.
// - double task snapshots and clears double accumulator only.
// - every report interval raise report/double events for nonzero accumulators.
// - shortcuts let double event trigger motion or double clear task.
// - enabled decoder owns its pins; processor cannot drive, can still read.
// - phase a, phase b, led routed to own selected pin; disconnected unrouted.
// - selections apply only while enabled; otherwise pins act as gpio.
// - compare pairs: 0 none, 1 forward, -1 reverse, 2 double.
// - sample event raised each time a new value is written to sample.
module qd_decoder (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [31:0] pin_in_i,
  input wire [31:0] gpio_out_i,
  input wire [31:0] gpio_oe_i,
  output wire [31:0] pin_out_o,
  output wire [31:0] pin_oe_o,
  output wire [31:0] pin_owned_o
);

  // integer tick count cut to the divider width on purpose
  localparam integer TICK_LAST_I = `QD_TICK_CYC - 1;
  localparam [4:0] TICK_LAST = TICK_LAST_I[4:0];

  // byte-lane merge for partial writes
  function [31:0] qd_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
      qd_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          qd_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // selected pin level, zero when disconnected
  function qd_pin;
    input [31:0] psel;
    input [31:0] pins;
    begin
      qd_pin = psel[`QD_PSEL_DISC_BIT] ? 1'b0 : pins[psel[4:0]];
    end
  endfunction

  // pair compare: 00 none, 01 forward, 11 reverse, 10 double
  function [1:0] qd_step;
    input [1:0] prev_ab;
    input [1:0] cur_ab;
    begin
      case ({prev_ab, cur_ab})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: qd_step = 2'b01;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: qd_step = 2'b11;
        4'b0011, 4'b0110, 4'b1001, 4'b1100: qd_step = 2'b10;
        default: qd_step = 2'b00;
      endcase
    end
  endfunction

  reg ack;
  reg [31:0] rdata;
  reg enable;
  reg led_polarity;
  reg [3:0] sample_period;
  reg [7:0] report_interval;
  reg [31:0] led_pin_select;
  reg [31:0] a_pin_select;
  reg [31:0] b_pin_select;
  reg debounce_enable;
  reg [8:0] led_lead_time;
  reg [1:0] shorts;
  reg running;
  reg [4:0] tick_cnt;
  reg [17:0] per_cnt;
  reg [1:0] deb_ref;
  reg [1:0] deb_same;
  reg [1:0] deb_out;
  reg [1:0] prev_ab;
  reg primed;
  reg [31:0] sample;
  reg [15:0] motion_accumulator;
  reg [15:0] motion_snapshot;
  reg [3:0] double_transition_accumulator;
  reg [3:0] double_snapshot;
  reg [7:0] rep_cnt;
  reg dbl_pulse;
  reg ev_sample;
  reg ev_report;
  reg ev_accumulator_overflow_event;
  reg ev_double;
  reg ev_stopped;
  reg led_level;

  // bus decode: a request is fresh until its ack, so a held request acts once
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
  wire wr = bus_req & wb_we_i;
  wire wr_lo = wr & wb_sel_i[0];

  // tasks fire on a write of one in bit zero
  wire task_start = wr_lo & wb_dat_i[0] & (wb_adr_i == `QD_TASK_START);
  wire task_stop = wr_lo & wb_dat_i[0] & (wb_adr_i == `QD_TASK_STOP);
  wire task_both = wr_lo & wb_dat_i[0] & (wb_adr_i == `QD_TASK_CLR_BOTH);
  wire task_motion = wr_lo & wb_dat_i[0] & (wb_adr_i == `QD_TASK_CLR_MOTION);
  wire task_double = wr_lo & wb_dat_i[0] & (wb_adr_i == `QD_TASK_CLR_DOUBLE);
  // a write of zero to an event register clears that event
  wire ev_clr = wr_lo & ~wb_dat_i[0];

  // 1 us tick shared by lead time, period and debounce
  wire tick = (tick_cnt == TICK_LAST);
  // codes above the top one act as the top one, so the period never overflows
  wire [3:0] sp_eff = (sample_period > `QD_SP_MAX) ? `QD_SP_MAX : sample_period;
  wire [17:0] period_len = 18'd128 << sp_eff;
  wire period_end = (per_cnt == period_len - 18'd1);
  wire sample_now = running & tick & period_end;
  // lead longer than the period simply keeps the led lit
  wire lead_on = ({9'h000, led_lead_time} >= period_len) |
                 (per_cnt >= period_len - {9'h000, led_lead_time});
  wire led_on = running & (debounce_enable | lead_on);

  // lead time merged by byte lane, then cut to its nine bits
  wire [31:0] lead_merged = qd_merge({23'h0, led_lead_time}, wb_dat_i, wb_sel_i);

  wire [1:0] raw_ab = {qd_pin(a_pin_select, pin_in_i), qd_pin(b_pin_select, pin_in_i)};
  // filter verdict for the period now ending: the level passes only if every tick agreed
  wire [1:0] deb_agree = deb_same & ~(raw_ab ^ deb_ref);
  wire [1:0] deb_next = (deb_agree & deb_ref) | (~deb_agree & deb_out);

  // decoder takes the verdict of the period just ended, so debounce costs up to one period
  wire [1:0] cur_ab = debounce_enable ? deb_next : raw_ab;
  wire [1:0] step = qd_step(prev_ab, cur_ab);
  // the first sample after start only primes the previous pair
  wire samp_valid = sample_now & primed;
  wire step_up = samp_valid & (step == 2'b01);
  wire step_dn = samp_valid & (step == 2'b11);
  wire step_dbl = samp_valid & (step == 2'b10);

  // saturate instead of wrapping: a wrapped count would flip the reported direction
  wire acc_ovf = (step_up & (motion_accumulator == 16'h7fff)) |
                 (step_dn & (motion_accumulator == 16'h8000));
  wire dbl_ovf = step_dbl & (double_transition_accumulator == 4'hf);
  wire [15:0] acc_delta = (step_up & ~acc_ovf) ? 16'h0001 :
                          (step_dn & ~acc_ovf) ? 16'hffff : 16'h0000;
  wire [15:0] acc_upd = motion_accumulator + acc_delta;
  wire [3:0] dbl_upd = double_transition_accumulator +
                       {3'b000, step_dbl & ~dbl_ovf};
  // a zero interval would never report, so it counts as one
  wire [7:0] rep_len = (report_interval == 8'h00) ? 8'h01 : report_interval;
  wire rep_hit = samp_valid & (rep_cnt + 8'h01 >= rep_len);
  // shortcut fires the cycle after the double event
  wire clr_motion = task_both | task_motion | (dbl_pulse & shorts[`QD_SHORT_MOTION_BIT]);
  wire clr_double = task_both | task_double | (dbl_pulse & shorts[`QD_SHORT_DOUBLE_BIT]);

  // wishbone slave: one wait state, ack for one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      ack <= bus_req;
      if (bus_req & ~wb_we_i) begin
        case (wb_adr_i)
          `QD_EV_SAMPLE: rdata <= {31'h0, ev_sample};
          `QD_EV_REPORT: rdata <= {31'h0, ev_report};
          `QD_EV_ACCUMULATOR_OVERFLOW_EVENT: rdata <= {31'h0, ev_accumulator_overflow_event};
          `QD_EV_DOUBLE: rdata <= {31'h0, ev_double};
          `QD_EV_STOPPED: rdata <= {31'h0, ev_stopped};
          `QD_SHORTS: rdata <= {30'h0, shorts};
          `QD_ENABLE: rdata <= {31'h0, enable};
          `QD_LED_POLARITY: rdata <= {31'h0, led_polarity};
          `QD_SAMPLE_PERIOD: rdata <= {28'h0, sample_period};
          `QD_SAMPLE: rdata <= sample;
          `QD_REPORT_INTERVAL: rdata <= {24'h0, report_interval};
          `QD_MOTION_ACC: rdata <= {{16{motion_accumulator[15]}}, motion_accumulator};
          `QD_MOTION_SNAP: rdata <= {{16{motion_snapshot[15]}}, motion_snapshot};
          `QD_LED_PIN_SELECT: rdata <= led_pin_select;
          `QD_A_PIN_SELECT: rdata <= a_pin_select;
          `QD_B_PIN_SELECT: rdata <= b_pin_select;
          `QD_DEBOUNCE_ENABLE: rdata <= {31'h0, debounce_enable};
          `QD_LED_LEAD_TIME: rdata <= {23'h0, led_lead_time};
          `QD_DOUBLE_ACC: rdata <= {28'h0, double_transition_accumulator};
          `QD_DOUBLE_SNAP: rdata <= {28'h0, double_snapshot};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // configuration registers, byte lanes honoured
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 1'b0;
      led_polarity <= 1'b0;
      sample_period <= `QD_SP_RESET;
      report_interval <= `QD_RP_RESET;
      led_pin_select <= `QD_PSEL_RESET;
      a_pin_select <= `QD_PSEL_RESET;
      b_pin_select <= `QD_PSEL_RESET;
      debounce_enable <= 1'b0;
      led_lead_time <= `QD_LEAD_RESET;
      shorts <= 2'b00;
    end else if (wr) begin
      case (wb_adr_i)
        `QD_SHORTS: shorts <= wb_sel_i[0] ? wb_dat_i[1:0] : shorts;
        `QD_ENABLE: enable <= wb_sel_i[0] ? wb_dat_i[0] : enable;
        `QD_LED_POLARITY: led_polarity <= wb_sel_i[0] ? wb_dat_i[0] : led_polarity;
        `QD_SAMPLE_PERIOD: sample_period <= wb_sel_i[0] ? wb_dat_i[3:0] : sample_period;
        `QD_REPORT_INTERVAL: report_interval <= wb_sel_i[0] ? wb_dat_i[7:0] : report_interval;
        `QD_LED_PIN_SELECT: led_pin_select <= qd_merge(led_pin_select, wb_dat_i, wb_sel_i);
        `QD_A_PIN_SELECT: a_pin_select <= qd_merge(a_pin_select, wb_dat_i, wb_sel_i);
        `QD_B_PIN_SELECT: b_pin_select <= qd_merge(b_pin_select, wb_dat_i, wb_sel_i);
        `QD_DEBOUNCE_ENABLE: debounce_enable <= wb_sel_i[0] ? wb_dat_i[0] : debounce_enable;
        `QD_LED_LEAD_TIME: led_lead_time <= lead_merged[8:0];
        default: shorts <= shorts;
      endcase
    end
  end

  // run control, tick divider and sample period counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      running <= 1'b0;
      tick_cnt <= 5'h00;
      per_cnt <= 18'h00000;
    end else begin
      tick_cnt <= tick ? 5'h00 : tick_cnt + 5'h01;
      if (task_stop | ~enable) begin
        running <= 1'b0;
      end else if (task_start) begin
        running <= 1'b1;
      end
      if (~running | task_start) begin
        per_cnt <= 18'h00000;
      end else if (tick) begin
        per_cnt <= period_end ? 18'h00000 : per_cnt + 18'h00001;
      end
    end
  end

  // debounce: every tick of a period must agree before the level passes
  always @(posedge clk_i) begin
    if (rst_i) begin
      deb_ref <= 2'b00;
      deb_same <= 2'b00;
      deb_out <= 2'b00;
    end else if (running & tick) begin
      if (per_cnt == 18'h00000) begin
        deb_ref <= raw_ab;
        deb_same <= 2'b11;
      end else begin
        deb_same <= deb_same & ~(raw_ab ^ deb_ref);
      end
      if (period_end) begin
        deb_out <= deb_next;
      end
    end
  end

  // decode, accumulate, snapshot and report
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_ab <= 2'b00;
      primed <= 1'b0;
      sample <= 32'h00000000;
      motion_accumulator <= 16'h0000;
      motion_snapshot <= 16'h0000;
      double_transition_accumulator <= 4'h0;
      double_snapshot <= 4'h0;
      rep_cnt <= 8'h00;
      dbl_pulse <= 1'b0;
    end else begin
      if (task_start) begin
        primed <= 1'b0;
        rep_cnt <= 8'h00;
      end else if (sample_now) begin
        prev_ab <= cur_ab;
        primed <= 1'b1;
        if (samp_valid) begin
          rep_cnt <= rep_hit ? 8'h00 : rep_cnt + 8'h01;
        end
      end
      // sample register holds the step as 0, 1, -1 or 2, extended to the word
      if (samp_valid) begin
        sample <= {{30{step[1] & step[0]}}, step};
      end
      // snapshot takes the value including a concurrent step, so nothing is lost
      motion_accumulator <= clr_motion ? 16'h0000 : acc_upd;
      if (clr_motion) begin
        motion_snapshot <= acc_upd;
      end
      double_transition_accumulator <= clr_double ? 4'h0 : dbl_upd;
      if (clr_double) begin
        double_snapshot <= dbl_upd;
      end
      // double event pulse feeds the shortcuts one clock later
      dbl_pulse <= rep_hit & (dbl_upd != 4'h0);
    end
  end

  // sticky event flags: a set in the clearing cycle wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      ev_sample <= 1'b0;
      ev_report <= 1'b0;
      ev_accumulator_overflow_event <= 1'b0;
      ev_double <= 1'b0;
      ev_stopped <= 1'b0;
    end else begin
      ev_sample <= samp_valid | (ev_sample & ~(ev_clr & (wb_adr_i == `QD_EV_SAMPLE)));
      ev_report <= (rep_hit & (acc_upd != 16'h0000)) |
                   (ev_report & ~(ev_clr & (wb_adr_i == `QD_EV_REPORT)));
      ev_accumulator_overflow_event <= acc_ovf | dbl_ovf | (ev_accumulator_overflow_event & ~(ev_clr & (wb_adr_i == `QD_EV_ACCUMULATOR_OVERFLOW_EVENT)));
      ev_double <= (rep_hit & (dbl_upd != 4'h0)) |
                   (ev_double & ~(ev_clr & (wb_adr_i == `QD_EV_DOUBLE)));
      ev_stopped <= task_stop | (ev_stopped & ~(ev_clr & (wb_adr_i == `QD_EV_STOPPED)));
    end
  end

  // led level registered so the pin sees a clean edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      led_level <= 1'b0;
    end else begin
      led_level <= led_polarity ? led_on : ~led_on;
    end
  end

  // pin ownership: per pin, decoder signals override gpio only while enabled
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_pin
      wire led_here = enable & ~led_pin_select[`QD_PSEL_DISC_BIT] &
                      (led_pin_select[4:0] == gi);
      wire a_here = enable & ~a_pin_select[`QD_PSEL_DISC_BIT] & (a_pin_select[4:0] == gi);
      wire b_here = enable & ~b_pin_select[`QD_PSEL_DISC_BIT] & (b_pin_select[4:0] == gi);
      assign pin_out_o[gi] = led_here ? led_level : gpio_out_i[gi];
      // phase pins are held as inputs regardless of gpio drive
      assign pin_oe_o[gi] = led_here | (~(a_here | b_here) & gpio_oe_i[gi]);
      assign pin_owned_o[gi] = led_here | a_here | b_here;
    end
  endgenerate

  // bus outputs straight from their flip-flops
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

endmodule // qd_decoder

// file: qd_decoder_regs.vh
`ifndef QD_DECODER_REGS_VH
`define QD_DECODER_REGS_VH

// register byte offsets
`define QD_TASK_START 12'h000
`define QD_TASK_STOP 12'h004
`define QD_TASK_CLR_BOTH 12'h008
`define QD_TASK_CLR_MOTION 12'h00c
`define QD_TASK_CLR_DOUBLE 12'h010
`define QD_EV_SAMPLE 12'h100
`define QD_EV_REPORT 12'h104
`define QD_EV_ACCUMULATOR_OVERFLOW_EVENT 12'h108
`define QD_EV_DOUBLE 12'h10c
`define QD_EV_STOPPED 12'h110
`define QD_SHORTS 12'h200
`define QD_ENABLE 12'h500
`define QD_LED_POLARITY 12'h504
`define QD_SAMPLE_PERIOD 12'h508
`define QD_SAMPLE 12'h50c
`define QD_REPORT_INTERVAL 12'h510
`define QD_MOTION_ACC 12'h514
`define QD_MOTION_SNAP 12'h518
`define QD_LED_PIN_SELECT 12'h51c
`define QD_A_PIN_SELECT 12'h520
`define QD_B_PIN_SELECT 12'h524
`define QD_DEBOUNCE_ENABLE 12'h528
`define QD_LED_LEAD_TIME 12'h540
`define QD_DOUBLE_ACC 12'h544
`define QD_DOUBLE_SNAP 12'h548

// field positions
`define QD_PSEL_DISC_BIT 31
`define QD_SHORT_MOTION_BIT 0
`define QD_SHORT_DOUBLE_BIT 1

// reset values
`define QD_PSEL_RESET 32'hffffffff
`define QD_SP_RESET 4'h0
`define QD_RP_RESET 8'h01
`define QD_LEAD_RESET 9'h010

// timing: 1 us tick from the system clock
`define QD_CLK_NS 40
`define QD_TICK_NS 1000
`define QD_TICK_CYC ((`QD_TICK_NS + `QD_CLK_NS - 1) / `QD_CLK_NS)
`define QD_SP_BASE_US 128
`define QD_SP_MAX 4'ha

`endif

// file: qd_encoder_model.sv
// far-side incremental encoder: two phases in gray order, one step per call
module qd_encoder_model (
  input wire logic clk_i,
  output logic phase_a_o,
  output logic phase_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos = 2'b00;

  // a move of 2 flips both phases at once, which is how a double transition looks
  task automatic move(input int dir);
    @(posedge clk_i);
    pos <= pos + dir[1:0];
  endtask

  // gray code keeps one phase changing at a time for single steps
  assign phase_a_o = pos[1];
  assign phase_b_o = pos[1] ^ pos[0];
endmodule // qd_encoder_model

// file: qd_decoder_properties.sv
`include "qd_decoder_regs.vh"

module qd_decoder_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [31:0] gpio_out_i,
  input wire [31:0] gpio_oe_i,
  input wire [31:0] pin_out_o,
  input wire [31:0] pin_oe_o,
  input wire [31:0] pin_owned_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fresh request is one not yet answered
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 12'h0fc |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_sample_code: assert property (req && !wb_we_i && wb_adr_i == `QD_SAMPLE |=>
    wb_dat_o inside {32'h0, 32'h1, 32'hffffffff, 32'h2})
    else $error("sample register holds an illegal code");
  a_gpio_out_pass: assert property (((pin_out_o ^ gpio_out_i) & ~pin_owned_o) == 32'h0)
    else $error("unowned pin value not from gpio");
  a_gpio_oe_pass: assert property (((pin_oe_o ^ gpio_oe_i) & ~pin_owned_o) == 32'h0)
    else $error("unowned pin enable not from gpio");
  a_owned_limit: assert property ($countones(pin_owned_o) <= 3)
    else $error("more than three pins owned");
  a_one_led_drive: assert property ($countones(pin_owned_o & pin_oe_o) <= 1)
    else $error("decoder drives more than the led pin");
  a_owned_stable: assert property (!(wb_cyc_i && wb_we_i) ##1 !wb_ack_o |-> $stable(pin_owned_o))
    else $error("ownership changed without a write");

  c_write: cover property (req && wb_we_i);
  c_owned: cover property (pin_owned_o == 32'h7);
  c_sample_read: cover property (req && wb_adr_i == `QD_SAMPLE);
endmodule // qd_decoder_properties

bind qd_decoder qd_decoder_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .pin_owned_o(pin_owned_o));

// file: test_quadrature_decoder_accumulate.sv
`include "qd_decoder_regs.vh"

module test_quadrature_decoder_accumulate;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, gpio_out_i = 32'h0, gpio_oe_i = 32'h0, noise = 32'h0, rd;
  wire [31:0] wb_dat_o, pin_out_o, pin_oe_o, pin_owned_o;
  wire wb_ack_o, enc_a, enc_b;
  // led line has a pull-up; undriven gpio pins float and show noise
  wire led_line = pin_oe_o[2] ? pin_out_o[2] : 1'b1;
  wire [31:0] pin_in_i = {(pin_oe_o[31:3] & pin_out_o[31:3]) | (~pin_oe_o[31:3] & noise[31:3]),
    led_line, enc_b, enc_a};
  int fail_count = 0;
  int total_checks = 0;
  int exp_acc, exp_dbl, n;
  int moves[$] = '{1, 1, 1, -1, 2, 1};

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    noise <= $urandom;
  end

  qd_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_in_i(pin_in_i), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pin_owned_o(pin_owned_o));

  qd_encoder_model i_enc (.clk_i(clk_i), .phase_a_o(enc_a), .phase_b_o(enc_b));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // values read right after the edge are the ones it sampled; the watchdog ends a hang
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(what, rd, e);
  endtask

  // one sample period at the reset setting, plus margin
  task automatic wait_period();
    repeat (3400) @(posedge clk_i);
  endtask

  // clocks of the next whole pulse at level lvl on the led pin
  task automatic led_width(input logic lvl, output int cnt);
    cnt = 0;
    do @(posedge clk_i); while (pin_out_o[2] === lvl);
    do @(posedge clk_i); while (pin_out_o[2] !== lvl);
    do begin
      @(posedge clk_i);
      cnt++;
    end while (pin_out_o[2] === lvl);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // cut a hang short: the sequence needs about 52000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    close_out();
  end

  initial begin
    void'($urandom(47));
    gpio_out_i <= $urandom;
    gpio_oe_i <= $urandom & 32'hfffffff8;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("sample_period", `QD_SAMPLE_PERIOD, 32'h0);
    rchk("report_interval", `QD_REPORT_INTERVAL, 32'h1);
    rchk("led_lead_time", `QD_LED_LEAD_TIME, 32'h10);
    rchk("led_pin_select", `QD_LED_PIN_SELECT, `QD_PSEL_RESET);
    rchk("unmapped", 12'h0fc, 32'h0);
    check("owned idle", pin_owned_o, 32'h0);
    $display("test reset_values done");
    bus(`QD_A_PIN_SELECT, 1'b1, 32'h0);
    bus(`QD_B_PIN_SELECT, 1'b1, 32'h1);
    bus(`QD_LED_PIN_SELECT, 1'b1, 32'h2);
    bus(`QD_LED_POLARITY, 1'b1, 32'h1);
    bus(`QD_ENABLE, 1'b1, 32'h1);
    check("owned", pin_owned_o, 32'h7);
    check("phase oe", {29'h0, pin_oe_o[2:0]}, 32'h4);
    $display("test pin_ownership done");
    bus(`QD_TASK_START, 1'b1, 32'h1);
    wait_period();
    exp_acc = 0;
    exp_dbl = 0;
    // each move stays put a full period so it is sampled exactly once
    foreach (moves[i]) begin
      i_enc.move(moves[i]);
      exp_acc += (moves[i] == 2) ? 0 : moves[i];
      exp_dbl += (moves[i] == 2);
      wait_period();
    end
    rchk("motion_acc", `QD_MOTION_ACC, exp_acc);
    rchk("double_acc", `QD_DOUBLE_ACC, exp_dbl);
    rchk("sample_event", `QD_EV_SAMPLE, 32'h1);
    rchk("report_event", `QD_EV_REPORT, 32'h1);
    rchk("double_event", `QD_EV_DOUBLE, 32'h1);
    bus(`QD_TASK_CLR_BOTH, 1'b1, 32'h1);
    rchk("motion_snap", `QD_MOTION_SNAP, exp_acc);
    rchk("double_snap", `QD_DOUBLE_SNAP, exp_dbl);
    rchk("motion_cleared", `QD_MOTION_ACC, 32'h0);
    rchk("double_cleared", `QD_DOUBLE_ACC, 32'h0);
    $display("test accumulate done");
    i_enc.move(2);
    wait_period();
    bus(`QD_TASK_CLR_MOTION, 1'b1, 32'h1);
    rchk("motion_snap_only", `QD_MOTION_SNAP, 32'h0);
    rchk("double_kept", `QD_DOUBLE_ACC, 32'h1);
    bus(`QD_TASK_CLR_DOUBLE, 1'b1, 32'h1);
    rchk("double_snap_only", `QD_DOUBLE_SNAP, 32'h1);
    rchk("double_only_cleared", `QD_DOUBLE_ACC, 32'h0);
    $display("test single_clears done");
    // led lit for the lead time before each sample, in either polarity
    bus(`QD_LED_POLARITY, 1'b1, 32'h0);
    led_width(1'b0, n);
    check("led lead low", n, `QD_LEAD_RESET * `QD_TICK_CYC);
    bus(`QD_LED_POLARITY, 1'b1, 32'h1);
    led_width(1'b1, n);
    check("led lead high", n, `QD_LEAD_RESET * `QD_TICK_CYC);
    $display("test led_strobe done");
    // just after a sample: debounce on, then a step in mid period
    bus(`QD_DEBOUNCE_ENABLE, 1'b1, 32'h1);
    repeat (1600) @(posedge clk_i);
    i_enc.move(1);
    exp_acc = 1;
    n = 0;
    repeat (1700) begin
      @(posedge clk_i);
      n += (pin_out_o[2] !== 1'b1);
    end
    check("led steady", n, 0);
    rchk("debounce lag", `QD_MOTION_ACC, 32'h0);
    repeat (3200) @(posedge clk_i);
    rchk("debounce pass", `QD_MOTION_ACC, exp_acc);
    // a pulse shorter than one period never passes the filter
    i_enc.move(1);
    repeat (100) @(posedge clk_i);
    i_enc.move(-1);
    repeat (6800) @(posedge clk_i);
    rchk("glitch dropped", `QD_MOTION_ACC, exp_acc);
    // double event snapshots and clears both through the shortcuts
    bus(`QD_SHORTS, 1'b1, 32'h3);
    i_enc.move(2);
    exp_dbl = 1;
    repeat (6800) @(posedge clk_i);
    rchk("short double snap", `QD_DOUBLE_SNAP, exp_dbl);
    rchk("short motion snap", `QD_MOTION_SNAP, exp_acc);
    rchk("short double clr", `QD_DOUBLE_ACC, 32'h0);
    rchk("short motion clr", `QD_MOTION_ACC, 32'h0);
    $display("test debounce done");
    bus(`QD_ENABLE, 1'b1, 32'h0);
    check("owned released", pin_owned_o, 32'h0);
    check("oe released", pin_oe_o, gpio_oe_i);
    $display("test release done");
    close_out();
  end
endmodule // test_quadrature_decoder_accumulate
